// >>> core/sdp_cfg.svh
`ifndef SDP_CFG_SVH
`define SDP_CFG_SVH

// ==========================================================
// Array geometry
`define SDP_PORTS 2
`define SDP_ADDR_W 16
`define SDP_DATA_W 18
`define SDP_LANE_W 9
`define SDP_LANES 2
`define SDP_WORDS 65536

// ==========================================================
// Lane positions inside a word
`define SDP_LOWER_LSB 0
`define SDP_UPPER_LSB 9
`define SDP_LOWER_LANE 0
`define SDP_UPPER_LANE 1

// ==========================================================
// Reset and constant values
`define SDP_ADDR_ZERO 16'h0000
`define SDP_ADDR_STEP 16'h0001
`define SDP_DATA_ZERO 18'h00000
`define SDP_LANES_OFF 2'h0

`endif

// >>> core/sdp_pkg.sv
`include "sdp_cfg.svh"

package sdp_pkg;

   // ==========================================================
   // Types
   typedef logic [`SDP_ADDR_W-1:0] sdp_addr_t;
   typedef logic [`SDP_DATA_W-1:0] sdp_data_t;
   typedef logic [`SDP_LANES-1:0] sdp_lane_t;

   // Output readiness of a port, walked on consecutive selected clocks
   typedef enum logic [1:0] {
      SDP_ST_STANDBY = 2'b00,
      SDP_ST_WAKE = 2'b01,
      SDP_ST_ACTIVE = 2'b10
   } sdp_state_t;

endpackage : sdp_pkg

// >>> core/sdp_ctr_if.sv
`timescale 1ns/1ns

// ==========================================================
// Address controls from the port logic to its counter
interface sdp_ctr_if;
   import sdp_pkg::*;
   sdp_addr_t ext_addr;
   logic address_strobe_n;
   logic count_advance_n;
   logic count_clear_n;
   sdp_addr_t access_addr;

   modport ctl (
      output ext_addr,
      output address_strobe_n,
      output count_advance_n,
      output count_clear_n,
      input access_addr
   );

   modport ctr (
      input ext_addr,
      input address_strobe_n,
      input count_advance_n,
      input count_clear_n,
      output access_addr
   );
endinterface : sdp_ctr_if

// >>> core/sdp_addr_ctr.sv
`timescale 1ns/1ns
`include "sdp_cfg.svh"

// ==========================================================
// Per-port address counter
module sdp_addr_ctr
   import sdp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   sdp_ctr_if.ctr bus
);

   sdp_addr_t count;
   sdp_addr_t next_count;

   // Address used by the access in this cycle; clear has the final say
   always_comb begin
      if (!bus.count_clear_n) begin
         next_count = `SDP_ADDR_ZERO;
      end else if (!bus.address_strobe_n) begin
         next_count = bus.ext_addr;
      end else if (!bus.count_advance_n) begin
         next_count = sdp_addr_t'(count + `SDP_ADDR_STEP);
      end else begin
         next_count = count;
      end
   end

   // Counter follows the access address so a later advance continues from it
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count <= `SDP_ADDR_ZERO;
      end else begin
         count <= next_count;
      end
   end

   assign bus.access_addr = next_count;

endmodule : sdp_addr_ctr

// >>> core/sdp_ram.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "sdp_cfg.svh"

// Behaviour
// - All inputs except output enable and mode select are taken on the rising clock edge.
// - Data outputs float after the next edge when deselected or both bytes off.
// - Address strobe low loads the external address on every edge unless counter clear is low.
// - Access address is zero under counter clear, else external address under strobe, else counter output.
// - Advance without strobe or clear increments the address; incremented address is accessed.
// - With neither strobe, advance nor clear the address holds and read data stays.
// - Counter clear forces address zero; same-cycle access uses address zero.
// - One deselected cycle puts the port into low-power standby.
// - Pipelined outputs return only after three consecutive selected cycles.
// - Upper and lower halves drive independently, per byte enable at issue.
// - Output drive state in a cycle follows controls of the previous cycle.
// - Opposite-port write is seen by a read issued on a later edge.
// - Input registers capture on rising edge; array write lands on that same rising edge.
// - Both ports identical and independent, either may read or write.
// - Depth expansion by shared address and chip enables, no decode.
// - Mode select high picks pipelined, low picks flow-through, per port.

// ==========================================================
// Dual-port synchronous RAM, port logic and storage
module sdp_ram
   import sdp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [`SDP_PORTS-1:0][`SDP_ADDR_W-1:0] port_addr,
   input wire logic [`SDP_PORTS-1:0][`SDP_DATA_W-1:0] port_wdata,
   input wire logic [`SDP_PORTS-1:0] read_write,
   input wire logic [`SDP_PORTS-1:0] chip_select_low_n,
   input wire logic [`SDP_PORTS-1:0] chip_select_high,
   input wire logic [`SDP_PORTS-1:0] upper_byte_n,
   input wire logic [`SDP_PORTS-1:0] lower_byte_n,
   input wire logic [`SDP_PORTS-1:0] address_strobe_n,
   input wire logic [`SDP_PORTS-1:0] count_advance_n,
   input wire logic [`SDP_PORTS-1:0] count_clear_n,
   input wire logic [`SDP_PORTS-1:0] output_enable_n,
   input wire logic [`SDP_PORTS-1:0] flow_pipeline_select,
   output logic [`SDP_PORTS-1:0][`SDP_DATA_W-1:0] port_rdata,
   output logic [`SDP_PORTS-1:0][`SDP_LANES-1:0] port_rdata_oe_n,
   output logic [`SDP_PORTS-1:0] standby
);

   // ==========================================================
   // Storage and per-port write requests
   sdp_data_t mem [`SDP_WORDS];
   logic [`SDP_PORTS-1:0] wr_en;
   sdp_addr_t wr_addr [`SDP_PORTS];
   sdp_data_t wr_data [`SDP_PORTS];
   sdp_lane_t wr_lane [`SDP_PORTS];

   // ==========================================================
   // Per-port read path and access control
   sdp_addr_t acc_addr [`SDP_PORTS];
   sdp_data_t flow_data [`SDP_PORTS];
   sdp_data_t pipe_data [`SDP_PORTS];
   sdp_lane_t flow_drive [`SDP_PORTS];
   sdp_lane_t pipe_drive [`SDP_PORTS];
   sdp_state_t state [`SDP_PORTS];
   sdp_state_t next_state [`SDP_PORTS];
   logic [`SDP_PORTS-1:0] chip_on;
   logic [`SDP_PORTS-1:0] is_read;
   sdp_lane_t lane_on [`SDP_PORTS];

   genvar p;
   generate
      for (p = 0; p < `SDP_PORTS; p++) begin : g_port
         sdp_ctr_if ctr_if ();

         sdp_addr_ctr u_ctr (
            .sys_clk (sys_clk),
            .sys_rst (sys_rst),
            .bus (ctr_if.ctr)
         );

         // Counter controls come straight from the pins of this port
         assign ctr_if.ext_addr = port_addr[p];
         assign ctr_if.address_strobe_n = address_strobe_n[p];
         assign ctr_if.count_advance_n = count_advance_n[p];
         assign ctr_if.count_clear_n = count_clear_n[p];
         assign acc_addr[p] = ctr_if.access_addr;

         // Decoded selects; either chip enable deselects on its own
         assign chip_on[p] = ~chip_select_low_n[p] & chip_select_high[p];
         assign lane_on[p] = {~upper_byte_n[p], ~lower_byte_n[p]};
         assign is_read[p] = read_write[p];

         // Write request, handed to the shared array process below
         assign wr_en[p] = chip_on[p] & ~read_write[p] & (|lane_on[p]);
         assign wr_addr[p] = acc_addr[p];
         assign wr_data[p] = port_wdata[p];
         assign wr_lane[p] = lane_on[p];

         // Power state walk: any deselected edge drops the port to standby
         always_comb begin
            if (!chip_on[p]) begin
               next_state[p] = SDP_ST_STANDBY;
            end else begin
               case (state[p])
                  SDP_ST_STANDBY: begin
                     next_state[p] = SDP_ST_WAKE;
                  end
                  SDP_ST_WAKE: begin
                     next_state[p] = SDP_ST_ACTIVE;
                  end
                  SDP_ST_ACTIVE: begin
                     next_state[p] = SDP_ST_ACTIVE;
                  end
                  default: begin
                     next_state[p] = SDP_ST_STANDBY;
                  end
               endcase
            end
         end

         // Power state register
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               state[p] <= SDP_ST_STANDBY;
            end else begin
               state[p] <= next_state[p];
            end
         end

         // First read stage: the flow-through output register.
         // Reading every edge, even when idle, keeps held data stable
         // because the address does not move while nothing steers it.
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               flow_data[p] <= `SDP_DATA_ZERO;
            end else begin
               flow_data[p] <= mem[acc_addr[p]];
            end
         end

         // Drive state of the flow-through stage, decided by this edge's controls
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               flow_drive[p] <= `SDP_LANES_OFF;
            end else if (chip_on[p] && is_read[p]) begin
               flow_drive[p] <= lane_on[p];
            end else begin
               flow_drive[p] <= `SDP_LANES_OFF;
            end
         end

         // Second read stage: one clock of extra latency in pipelined mode
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               pipe_data[p] <= `SDP_DATA_ZERO;
            end else begin
               pipe_data[p] <= flow_data[p];
            end
         end

         // Pipelined drive: a deselect or both lanes off still floats the
         // outputs after the very next edge, and after standby the outputs
         // come back only once three selected edges have passed.
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               pipe_drive[p] <= `SDP_LANES_OFF;
            end else if (!chip_on[p] || lane_on[p] == `SDP_LANES_OFF) begin
               pipe_drive[p] <= `SDP_LANES_OFF;
            end else if (state[p] == SDP_ST_ACTIVE) begin
               pipe_drive[p] <= flow_drive[p];
            end else begin
               pipe_drive[p] <= `SDP_LANES_OFF;
            end
         end

         // Mode select is static, so it picks the stage without a register.
         // The output enable gates the drive without waiting for the clock.
         always_comb begin
            if (flow_pipeline_select[p]) begin
               port_rdata[p] = pipe_data[p];
               port_rdata_oe_n[p] = ~(pipe_drive[p] & {`SDP_LANES{~output_enable_n[p]}});
            end else begin
               port_rdata[p] = flow_data[p];
               port_rdata_oe_n[p] = ~(flow_drive[p] & {`SDP_LANES{~output_enable_n[p]}});
            end
         end

         // Standby flag seen by the power logic of the port
         assign standby[p] = (state[p] == SDP_ST_STANDBY);
      end
   endgenerate

   // ==========================================================
   // Array write
   // The write lands at the edge that takes the inputs, so the opposite
   // port sees new data from its next edge on. If both ports write the
   // same word in one cycle, the higher port index wins; the result of
   // such a collision is undefined for the controller anyway.
   always_ff @(posedge sys_clk) begin
      for (int q = 0; q < `SDP_PORTS; q++) begin
         if (wr_en[q]) begin
            if (wr_lane[q][`SDP_LOWER_LANE]) begin
               mem[wr_addr[q]][`SDP_LOWER_LSB +: `SDP_LANE_W] <=
                  wr_data[q][`SDP_LOWER_LSB +: `SDP_LANE_W];
            end
            if (wr_lane[q][`SDP_UPPER_LANE]) begin
               mem[wr_addr[q]][`SDP_UPPER_LSB +: `SDP_LANE_W] <=
                  wr_data[q][`SDP_UPPER_LSB +: `SDP_LANE_W];
            end
         end
      end
   end

endmodule : sdp_ram

// >>> verif/sdp_bus_model.sv
`timescale 1ns/1ns
`include "sdp_cfg.svh"

// ==========================================================
// Controller-side view of both data buses
module sdp_bus_model
   import sdp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [`SDP_PORTS-1:0][`SDP_DATA_W-1:0] port_rdata,
   input wire logic [`SDP_PORTS-1:0][`SDP_LANES-1:0] port_rdata_oe_n,
   output logic [`SDP_PORTS-1:0][`SDP_DATA_W-1:0] bus_data
);
   sdp_data_t noise = 18'h2AAAA;

   // No pull on the bus, so a floating lane flips every cycle
   always_ff @(posedge sys_clk) begin
      noise <= ~noise;
   end

   // Each lane resolves on its own enable
   always_comb begin
      for (int p = 0; p < `SDP_PORTS; p++) begin
         bus_data[p][8:0] = port_rdata_oe_n[p][0] ? noise[8:0] : port_rdata[p][8:0];
         bus_data[p][17:9] = port_rdata_oe_n[p][1] ? noise[17:9] : port_rdata[p][17:9];
      end
   end
endmodule : sdp_bus_model

// >>> verif/sdp_ram_assertions.sv
`timescale 1ns/1ns
`include "sdp_cfg.svh"

// ==========================================================
// Pin-level checker, port 0 flow-through, port 1 pipelined
module sdp_ram_chk
   import sdp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [`SDP_PORTS-1:0] read_write,
   input wire logic [`SDP_PORTS-1:0] chip_select_low_n,
   input wire logic [`SDP_PORTS-1:0] chip_select_high,
   input wire logic [`SDP_PORTS-1:0] upper_byte_n,
   input wire logic [`SDP_PORTS-1:0] lower_byte_n,
   input wire logic [`SDP_PORTS-1:0] address_strobe_n,
   input wire logic [`SDP_PORTS-1:0] count_advance_n,
   input wire logic [`SDP_PORTS-1:0] count_clear_n,
   input wire logic [`SDP_PORTS-1:0] output_enable_n,
   input wire logic [`SDP_PORTS-1:0] flow_pipeline_select,
   input wire logic [`SDP_PORTS-1:0][`SDP_DATA_W-1:0] port_rdata,
   input wire logic [`SDP_PORTS-1:0][`SDP_LANES-1:0] port_rdata_oe_n,
   input wire logic [`SDP_PORTS-1:0] standby
);
   logic [1:0] on;
   logic [1:0] lanes;
   logic hold0;

   // Decoded selects
   assign on = ~chip_select_low_n & chip_select_high;
   assign lanes = ~upper_byte_n & ~lower_byte_n;
   assign hold0 = address_strobe_n[0] & count_advance_n[0] & count_clear_n[0];

   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // Steps of the pipelined port leaving standby and completing a read
   sequence wake_s;
      !on[1] ##1 (on[1] && flow_pipeline_select[1]);
   endsequence
   sequence pipe_rd_s;
      on[1] ##1 (on[1] && read_write[1] && lanes[1] && flow_pipeline_select[1]) ##1 (on[1] && lanes[1]);
   endsequence

   a_float_deselect: assert property (!on[0] |=> port_rdata_oe_n[0] == 2'h3)
      else $error("port 0 drove after deselect");
   a_write_no_drive: assert property (!read_write[0] && !flow_pipeline_select[0] |=> port_rdata_oe_n[0] == 2'h3)
      else $error("port 0 drove after a write");
   a_standby_entry: assert property (!on[1] |=> standby[1])
      else $error("port 1 missed standby");
   a_upper_float: assert property (upper_byte_n[0] |=> port_rdata_oe_n[0][1])
      else $error("upper lane drove while masked");
   a_oe_async: assert property (output_enable_n[0] |-> port_rdata_oe_n[0] == 2'h3)
      else $error("output enable ignored");
   a_pipe_wake: assert property (wake_s |=> port_rdata_oe_n[1] == 2'h3)
      else $error("pipelined port woke too early");
   a_pipe_drive: assert property (pipe_rd_s ##1 !output_enable_n[1] |-> port_rdata_oe_n[1] == 2'h0)
      else $error("pipelined read not driven");
   a_flow_drive: assert property (on[0] && read_write[0] && lanes[0] && !flow_pipeline_select[0]
      ##1 !output_enable_n[0] |-> port_rdata_oe_n[0] == 2'h0)
      else $error("flow read not driven");
   a_hold_data: assert property ((read_write == 2'h3 && on[0]) ##1 (read_write == 2'h3 && on[0] && hold0
      && !flow_pipeline_select[0]) |=> $stable(port_rdata[0]))
      else $error("held read data changed");
endmodule : sdp_ram_chk

bind sdp_ram sdp_ram_chk chk (.sys_clk, .sys_rst, .read_write, .chip_select_low_n, .chip_select_high,
   .upper_byte_n, .lower_byte_n, .address_strobe_n, .count_advance_n, .count_clear_n, .output_enable_n,
   .flow_pipeline_select, .port_rdata, .port_rdata_oe_n, .standby);

// >>> verif/tb.sv
`timescale 1ns/1ns
`include "sdp_cfg.svh"

module tb
   import sdp_pkg::*;
;
   localparam logic [2:0] LD = 3'h3, ADV = 3'h5, HOLD = 3'h7, CLR = 3'h6, CLR_LD = 3'h2;
   localparam sdp_data_t D1 = 18'h2A5A5, D2 = 18'h15A5A, D3 = 18'h0C3C3, D4 = 18'h3FE00;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   sdp_addr_t [1:0] port_addr = '0;
   sdp_data_t [1:0] port_wdata = '0;
   sdp_lane_t read_write = 2'h3, chip_select_low_n = 2'h3, chip_select_high = 2'h0, upper_byte_n = 2'h0;
   sdp_lane_t lower_byte_n = 2'h0, address_strobe_n = 2'h3, count_advance_n = 2'h3, count_clear_n = 2'h3;
   sdp_lane_t output_enable_n = 2'h0;
   sdp_lane_t flow_pipeline_select = 2'h2; // Port 0 flow-through, port 1 pipelined
   sdp_data_t [1:0] port_rdata, bus_data;
   logic [1:0][1:0] port_rdata_oe_n;
   sdp_lane_t standby;
   int mismatches = 0, tests_run = 0;

   always #20 sys_clk = ~sys_clk;

   sdp_ram dut (.sys_clk, .sys_rst, .port_addr, .port_wdata, .read_write, .chip_select_low_n,
      .chip_select_high, .upper_byte_n, .lower_byte_n, .address_strobe_n, .count_advance_n,
      .count_clear_n, .output_enable_n, .flow_pipeline_select, .port_rdata, .port_rdata_oe_n, .standby);
   sdp_bus_model bus (.sys_clk, .port_rdata, .port_rdata_oe_n, .bus_data);

   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One clock of port p; on return the flow output shows the previous call
   task automatic op(input int p, input logic sel, input logic rw, input logic [1:0] be,
                     input logic [2:0] ctl, input sdp_addr_t a, input sdp_data_t d);
      @(posedge sys_clk);
      chip_select_low_n[p] <= ~sel;
      chip_select_high[p] <= sel;
      read_write[p] <= rw;
      {upper_byte_n[p], lower_byte_n[p]} <= be;
      {address_strobe_n[p], count_advance_n[p], count_clear_n[p]} <= ctl;
      port_addr[p] <= a;
      port_wdata[p] <= d;
      #1;
   endtask : op

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // Guard against a stuck run
   initial begin
      repeat (2000) @(posedge sys_clk);
      mismatches++;
      print_verdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
      check(18'(standby), 18'h3);
      check(18'(port_rdata_oe_n), 18'hF);
      op(0, 1, 0, 2'h0, LD, 16'h0010, D1);
      op(0, 1, 0, 2'h0, ADV, 16'h0000, D2);
      check(18'(port_rdata_oe_n[0]), 18'h3);
      op(0, 1, 0, 2'h0, CLR_LD, 16'h0010, D3);
      op(0, 1, 1, 2'h0, LD, 16'h0010, '0);
      op(0, 1, 1, 2'h0, ADV, 16'h0000, '0);
      check(bus_data[0], D1);
      op(0, 1, 1, 2'h0, HOLD, 16'h0000, '0);
      check(bus_data[0], D2);
      op(0, 1, 1, 2'h0, HOLD, 16'h0000, '0);
      check(bus_data[0], D2);
      op(0, 1, 1, 2'h0, LD, 16'hFFFF, '0);
      check(bus_data[0], D2);
      op(0, 1, 1, 2'h0, ADV, 16'h0000, '0);
      op(0, 1, 1, 2'h1, LD, 16'h0010, '0);
      check(bus_data[0], D3);
      op(0, 1, 1, 2'h0, CLR, 16'h0010, '0);
      check(18'(port_rdata_oe_n[0]), 18'h1);
      check(18'(bus_data[0][17:9]), 18'(D1[17:9]));
      op(0, 0, 1, 2'h0, HOLD, 16'h0000, '0);
      check(bus_data[0], D3);
      op(0, 1, 1, 2'h0, HOLD, 16'h0000, '0);
      check(18'(port_rdata_oe_n[0]), 18'h3);
      check(18'(standby[0]), 18'h1);
      op(0, 1, 1, 2'h0, HOLD, 16'h0000, '0);
      output_enable_n[0] <= 1'b1;
      #1;
      check(18'(port_rdata_oe_n[0]), 18'h3);
      // Keep the enable off across one edge so the checker sees it too
      @(posedge sys_clk);
      output_enable_n[0] <= 1'b0;
      // Read-to-write turnaround: rewrite the word just read
      op(0, 1, 0, 2'h0, CLR, 16'h0000, D3);
      // Port 0 writes, pipelined port 1 wakes and reads it back
      op(0, 1, 0, 2'h0, LD, 16'h0020, D4);
      op(0, 1, 1, 2'h0, HOLD, 16'h0000, '0);
      op(1, 1, 1, 2'h0, LD, 16'h0020, '0);
      op(1, 1, 1, 2'h0, LD, 16'h0020, '0);
      op(1, 1, 1, 2'h0, LD, 16'h0020, '0);
      check(18'(port_rdata_oe_n[1]), 18'h3);
      op(1, 1, 1, 2'h0, LD, 16'h0020, '0);
      check(18'(port_rdata_oe_n[1]), 18'h0);
      check(bus_data[1], D4);
      // Let the pipelined read sequence complete in the checker
      repeat (2) @(posedge sys_clk);
      print_verdict();
   end
endmodule : tb
